// ---- common/weld_pkg.sv ----
// constants, types and register map of the part-hold weld sequencer
package weld_pkg;

  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int CUR_W   = 12;
  localparam int SCHED_N = 8;
  localparam int SIDX_W  = 3;
  localparam int PHASE_W = 8;
  localparam int EVT_W   = 4;
  localparam int VALVE_W = 3;
  localparam int IRQ_W   = 3;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_HI_LIM   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LO_LIM   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SCH_SEL  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_SCH_DATA = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 8'h20;

  // control register fields
  localparam int CTL_HEADLOCK  = 0;
  localparam int CTL_RST_MAP   = 1;
  localparam int CTL_ESC_MAP   = 2;
  localparam int CTL_LOCKOUT   = 3;
  localparam int CTL_SEQR      = 4;
  localparam int CTL_AUX_LSB   = 8;
  localparam int CTL_START_LSB = 16;
  localparam logic [DATA_W-1:0] CTRL_MASK = 32'h0007_0F1F;
  localparam logic [DATA_W-1:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [CUR_W-1:0]  HI_RST    = 12'hFFF;
  localparam logic [CUR_W-1:0]  LO_RST    = 12'h000;

  // status register fields
  localparam int STS_STATE_LSB = 0;
  localparam int STS_SIDX_LSB  = 4;
  localparam int STS_FAULT     = 8;
  localparam int STS_HELD      = 9;

  // interrupt bits
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_FAULT   = 1;
  localparam int IRQ_RELEASE = 2;

  // timing
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned LINE_HZ     = 60;
  localparam int unsigned LINE_CLKS   = CLK_HZ / LINE_HZ;
  localparam int unsigned POR_TIME_US = 10;
  localparam int unsigned POR_CLKS    = CLK_HZ / 1_000_000 * POR_TIME_US;
  localparam int          POR_W       = 12;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SQUEEZE, ST_WELD, ST_HOLD, ST_PART_HOLD, ST_POR
  } seq_state_t;

  typedef struct packed {
    logic [PHASE_W-1:0] squeezeTime;
    logic [PHASE_W-1:0] weldTime;
    logic [PHASE_W-1:0] holdTime;
    logic [VALVE_W-1:0] valves;
    logic [EVT_W-1:0]   events;
    logic               chained;
  } sched_t;

  typedef struct packed {
    logic firstStageInitiate;
    logic estopClosed;
    logic errorResetInput;
    logic escapeReleaseInput;
    logic keyTurned;
  } pins_in_t;

  typedef struct packed {
    logic [VALVE_W-1:0] headValves;
    logic               controlRelay;
    logic               isolationContactorOutput;
    logic               faultAlarmOutput;
    logic [EVT_W-1:0]   auxEventOutputs;
  } pins_out_t;

endpackage

// ---- hw/line_cycle_tick.sv ----
// line cycle enable pulse divider
`timescale 1ns/100ps
module line_cycle_tick #(
  parameter int unsigned PERIOD = 3333333
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable,
  output logic      tick
);
  localparam int W = $clog2(PERIOD + 1);
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);

  logic [W-1:0] cnt_q;

  // restarts while disabled so each phase counts whole cycles
  always_ff @(posedge clk) begin
    if (!rst_n || !enable) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= enable && (cnt_q == LAST);
    end
  end
endmodule // line_cycle_tick

// ---- hw/weld_sequencer.sv ----
// weld sequencer with part hold on current fault
//
// Overview of operation
// RQ1: part-hold mode and out-of-window current keep valves on after sequence.
// RQ2: current inside window turns valves off at end of hold.
// RQ3: isolation contactor output only during squeeze, weld and hold.
// RQ4: contactor drops at end of hold even with a current error.
// RQ5: alarm output on while the part is held for a current error.
// RQ6: valves and alarm stay on until the error is cleared.
// RQ7: estop open, error reset or escape closing ends the part hold.
// RQ8: error reset and escape release only when mapped to that function.
// RQ9: clearing the error turns all valves off then runs power-on reset.
// RQ10: with lockout key fitted, key must also be turned to release.
// RQ11: aux outputs nine to twelve follow per-schedule events when mapped.
// RQ12: chained schedule runs the next one; non-repeat ends the chain.
// RQ13: software keeps the sequencer function off for event valve control.
// RQ14: only the three head valves pass the control relay contacts.
// RQ15: closing first stage initiate starts the selected schedule.
// RQ16: squeeze, weld, hold in order, each counted in line cycles.
`timescale 1ns/100ps
module weld_sequencer
  import weld_pkg::*;
#(
  parameter int unsigned LINE_CLKS_P = weld_pkg::LINE_CLKS
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [weld_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [weld_pkg::DATA_W-1:0] regWdata,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic      [weld_pkg::DATA_W-1:0] regRdata,
  input  wire weld_pkg::pins_in_t         pinsIn,
  input  wire logic [weld_pkg::CUR_W-1:0]  currentValue,
  input  wire logic                       currentValid,
  output weld_pkg::pins_out_t             pinsOut,
  output logic                            irq
);
  import weld_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // declarations
  seq_state_t          state_q;
  logic [SIDX_W-1:0]   schedIdx_q;
  logic [PHASE_W-1:0]  phaseCnt_q;
  logic [POR_W-1:0]    porCnt_q;
  logic                faultSeen_q;
  logic                initPrev_q;
  logic [DATA_W-1:0]   ctrl_q;
  logic [CUR_W-1:0]    hiLim_q;
  logic [CUR_W-1:0]    loLim_q;
  logic [SIDX_W-1:0]   schSel_q;
  logic [IRQ_W-1:0]    irqStat_q;
  logic [IRQ_W-1:0]    irqEn_q;
  sched_t              schedMem [SCHED_N];
  pins_out_t           pinsOut_d;
  sched_t              cur;
  logic [PHASE_W-1:0]  phaseLen;
  logic                lineTick;
  logic                seqActive;
  logic                phaseDone;
  logic                startReq;
  logic                holdEnd;
  logic                takeHold;
  logic                chainNext;
  logic                relSrc;
  logic                relOk;
  logic                outOfWindow;
  logic [IRQ_W-1:0]    irqEvt;
  logic [IRQ_W-1:0]    irqClr;
  logic                headLock;
  logic [EVT_W-1:0]    auxMap;

  localparam logic [SIDX_W-1:0] LAST_SCHED = SIDX_W'(SCHED_N - 1);
  localparam logic [POR_W-1:0]  POR_LAST   = POR_W'(POR_CLKS - 1);

  assign cur       = schedMem[schedIdx_q];
  assign headLock  = ctrl_q[CTL_HEADLOCK];
  assign auxMap    = ctrl_q[CTL_AUX_LSB +: EVT_W];
  assign seqActive = (state_q == ST_SQUEEZE) || (state_q == ST_WELD) ||
                     (state_q == ST_HOLD);

  //////////////////////////////////////////////////////////////////////////
  // line cycle timing
  line_cycle_tick #(
    .PERIOD (LINE_CLKS_P)
  ) u_tick (
    .clk    (clk),
    .rst_n  (rst_n),
    .enable (seqActive),
    .tick   (lineTick)
  );

  always_comb begin
    case (state_q)
      ST_SQUEEZE: phaseLen = cur.squeezeTime;
      ST_WELD:    phaseLen = cur.weldTime;
      default:    phaseLen = cur.holdTime;
    endcase
  end

  // a zero length phase ends on its first line cycle
  assign phaseDone = lineTick &&
    (({1'b0, phaseCnt_q} + 9'd1) >= {1'b0, phaseLen}); // [RQ16]

  assign startReq  = pinsIn.firstStageInitiate && !initPrev_q; // [RQ15]
  assign holdEnd   = (state_q == ST_HOLD) && phaseDone &&
                     pinsIn.estopClosed;
  assign takeHold  = holdEnd && faultSeen_q && headLock; // [RQ1]
  assign chainNext = holdEnd && !takeHold && cur.chained &&
                     (schedIdx_q != LAST_SCHED); // [RQ12]

  assign relSrc = !pinsIn.estopClosed ||
    (pinsIn.errorResetInput && ctrl_q[CTL_RST_MAP]) ||
    (pinsIn.escapeReleaseInput && ctrl_q[CTL_ESC_MAP]); // [RQ7] [RQ8]
  assign relOk  = relSrc &&
    (!ctrl_q[CTL_LOCKOUT] || pinsIn.keyTurned); // [RQ10]

  assign outOfWindow = (currentValue > hiLim_q) ||
                       (currentValue < loLim_q);

  //////////////////////////////////////////////////////////////////////////
  // sequence state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      initPrev_q <= 1'b0;
    end else begin
      initPrev_q <= pinsIn.firstStageInitiate;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      schedIdx_q <= '0;
      phaseCnt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          phaseCnt_q <= '0;
          if (startReq && pinsIn.estopClosed) begin // [RQ15]
            schedIdx_q <= ctrl_q[CTL_START_LSB +: SIDX_W];
            state_q    <= ST_SQUEEZE;
          end
        end
        ST_SQUEEZE, ST_WELD, ST_HOLD: begin
          if (!pinsIn.estopClosed) begin
            state_q <= ST_POR;
          end else if (phaseDone) begin // [RQ16]
            phaseCnt_q <= '0;
            if (state_q == ST_SQUEEZE) begin
              state_q <= ST_WELD;
            end else if (state_q == ST_WELD) begin
              state_q <= ST_HOLD;
            end else if (takeHold) begin
              state_q <= ST_PART_HOLD; // [RQ1]
            end else if (chainNext) begin
              schedIdx_q <= schedIdx_q + SIDX_W'(1); // [RQ12]
              state_q    <= ST_SQUEEZE;
            end else begin
              state_q <= ST_IDLE; // [RQ2] [RQ12]
            end
          end else if (lineTick) begin
            phaseCnt_q <= phaseCnt_q + PHASE_W'(1);
          end
        end
        ST_PART_HOLD: begin
          if (relOk) begin
            state_q <= ST_POR; // [RQ7] [RQ9]
          end
        end
        default: begin
          if (porCnt_q == POR_LAST) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || state_q != ST_POR) begin
      porCnt_q <= '0;
    end else begin
      porCnt_q <= porCnt_q + POR_W'(1);
    end
  end

  // current error latch, cleared by a new start or power-on reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      faultSeen_q <= 1'b0;
    end else if (state_q == ST_WELD && currentValid && outOfWindow) begin
      faultSeen_q <= 1'b1;
    end else if (state_q == ST_POR ||
                 (state_q == ST_IDLE && startReq)) begin
      faultSeen_q <= 1'b0; // [RQ9]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output pins
  always_comb begin
    pinsOut_d = '0;
    pinsOut_d.controlRelay = (state_q != ST_POR) && pinsIn.estopClosed;
    if (seqActive || state_q == ST_PART_HOLD) begin
      pinsOut_d.headValves = cur.valves; // [RQ1] [RQ6]
    end
    if (!pinsOut_d.controlRelay) begin
      pinsOut_d.headValves = '0; // [RQ14]
    end
    pinsOut_d.isolationContactorOutput = seqActive; // [RQ3] [RQ4]
    pinsOut_d.faultAlarmOutput = (state_q == ST_PART_HOLD); // [RQ5]
    if (seqActive && !ctrl_q[CTL_SEQR]) begin
      pinsOut_d.auxEventOutputs = auxMap & cur.events; // [RQ11]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinsOut <= '0;
    end else begin
      pinsOut <= pinsOut_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register file
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q   <= CTRL_RST;
      hiLim_q  <= HI_RST;
      loLim_q  <= LO_RST;
      schSel_q <= '0;
      irqEn_q  <= '0;
    end else if (regWrite) begin
      if (regAddr == OFS_CTRL) begin
        ctrl_q <= regWdata & CTRL_MASK;
      end else if (regAddr == OFS_HI_LIM) begin
        hiLim_q <= regWdata[CUR_W-1:0];
      end else if (regAddr == OFS_LO_LIM) begin
        loLim_q <= regWdata[CUR_W-1:0];
      end else if (regAddr == OFS_SCH_SEL) begin
        schSel_q <= regWdata[SIDX_W-1:0];
      end else if (regAddr == OFS_IRQ_EN) begin
        irqEn_q <= regWdata[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < SCHED_N; i++) begin
        schedMem[i] <= '0;
      end
    end else if (regWrite && regAddr == OFS_SCH_DATA) begin
      schedMem[schSel_q] <= regWdata;
    end
  end

  assign irqEvt[IRQ_DONE]    = holdEnd && !takeHold && !chainNext;
  assign irqEvt[IRQ_FAULT]   = takeHold;
  assign irqEvt[IRQ_RELEASE] = (state_q == ST_PART_HOLD) && relOk;
  assign irqClr = (regWrite && regAddr == OFS_IRQ_CLR) ?
                  regWdata[IRQ_W-1:0] : '0;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqStat_q <= '0;
    end else begin
      irqStat_q <= (irqStat_q & ~irqClr) | irqEvt;
    end
  end

  assign irq = |(irqStat_q & irqEn_q);

  always_ff @(posedge clk) begin
    if (!rst_n || !regRead) begin
      regRdata <= '0;
    end else if (regAddr == OFS_CTRL) begin
      regRdata <= ctrl_q;
    end else if (regAddr == OFS_HI_LIM) begin
      regRdata <= {{(DATA_W-CUR_W){1'b0}}, hiLim_q};
    end else if (regAddr == OFS_LO_LIM) begin
      regRdata <= {{(DATA_W-CUR_W){1'b0}}, loLim_q};
    end else if (regAddr == OFS_SCH_SEL) begin
      regRdata <= {{(DATA_W-SIDX_W){1'b0}}, schSel_q};
    end else if (regAddr == OFS_SCH_DATA) begin
      regRdata <= schedMem[schSel_q];
    end else if (regAddr == OFS_STATUS) begin
      regRdata <= '0;
      regRdata[STS_STATE_LSB +: 3]    <= state_q;
      regRdata[STS_SIDX_LSB +: SIDX_W] <= schedIdx_q;
      regRdata[STS_FAULT]             <= faultSeen_q;
      regRdata[STS_HELD]              <= (state_q == ST_PART_HOLD);
    end else if (regAddr == OFS_IRQ_STAT) begin
      regRdata <= {{(DATA_W-IRQ_W){1'b0}}, irqStat_q};
    end else if (regAddr == OFS_IRQ_EN) begin
      regRdata <= {{(DATA_W-IRQ_W){1'b0}}, irqEn_q};
    end else begin
      regRdata <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_held2;
    state_q == ST_PART_HOLD ##1 state_q == ST_PART_HOLD;
  endsequence

  sequence s_cleanEnd;
    holdEnd && !faultSeen_q && !chainNext;
  endsequence

  AST_HOLD_VALVES_KEPT: // [RQ1] [RQ6]
    assert property (s_held2 |-> pinsOut.headValves ==
                     (cur.valves & {VALVE_W{pinsOut.controlRelay}}))
    else $error("valves not kept during part hold");

  AST_VALVES_OFF_AFTER_HOLD: // [RQ2]
    assert property (s_cleanEnd |-> ##2 pinsOut.headValves == '0)
    else $error("valves still on after clean hold end");

  AST_CONTACTOR_ACTIVE_ONLY: // [RQ3]
    assert property (pinsOut.isolationContactorOutput ==
      ($past(state_q) inside {ST_SQUEEZE, ST_WELD, ST_HOLD}))
    else $error("contactor output outside weld sequence");

  AST_CONTACTOR_OFF_IN_HOLD: // [RQ4]
    assert property (s_held2 |-> !pinsOut.isolationContactorOutput)
    else $error("contactor on while part held");

  AST_ALARM_FOLLOWS_HOLD: // [RQ5]
    assert property (pinsOut.faultAlarmOutput ==
                     ($past(state_q) == ST_PART_HOLD))
    else $error("alarm does not follow part hold");

  AST_FAULT_ENTERS_HOLD: // [RQ1]
    assert property (takeHold |=> state_q == ST_PART_HOLD ##1
                     pinsOut.faultAlarmOutput)
    else $error("current fault did not hold the part");

  AST_RELEASE_TO_POR: // [RQ7]
    assert property (state_q == ST_PART_HOLD && relOk |=>
                     state_q == ST_POR ##1 pinsOut.headValves == '0)
    else $error("release did not clear valves into reset");

  AST_NO_UNMAPPED_RELEASE: // [RQ8] [RQ10]
    assert property (state_q == ST_PART_HOLD && pinsIn.estopClosed &&
      (ctrl_q[CTL_LOCKOUT] ? !pinsIn.keyTurned :
       !(pinsIn.errorResetInput && ctrl_q[CTL_RST_MAP]) &&
       !(pinsIn.escapeReleaseInput && ctrl_q[CTL_ESC_MAP]))
      |=> state_q == ST_PART_HOLD)
    else $error("part released without valid source");

  AST_POR_VALVES_OFF: // [RQ9]
    assert property (state_q == ST_POR [*2] |->
                     pinsOut.headValves == '0 && !faultSeen_q)
    else $error("valves on or error kept during reset");

  AST_RELAY_GATES_VALVES: // [RQ14]
    assert property (pinsOut.headValves != '0 |-> pinsOut.controlRelay)
    else $error("head valve on without control relay");

  AST_AUX_ONLY_ACTIVE: // [RQ11]
    assert property (pinsOut.auxEventOutputs != '0 |->
      $past(seqActive) && ($past(auxMap) & pinsOut.auxEventOutputs) ==
      pinsOut.auxEventOutputs)
    else $error("aux output driven outside mapped event");

  AST_CHAIN_NEXT: // [RQ12]
    assert property (chainNext |=> state_q == ST_SQUEEZE &&
                     schedIdx_q == $past(schedIdx_q) + SIDX_W'(1))
    else $error("chained schedule did not follow");

  AST_START: // [RQ15]
    assert property (state_q == ST_IDLE && startReq && pinsIn.estopClosed
                     |=> state_q == ST_SQUEEZE)
    else $error("initiate did not start the schedule");

  AST_PHASE_ORDER: // [RQ16]
    assert property (state_q == ST_SQUEEZE ##1 state_q != ST_SQUEEZE |->
                     state_q inside {ST_WELD, ST_POR})
    else $error("weld did not follow squeeze");

endmodule // weld_sequencer

// ---- bench/weld_cell_model.sv ----
// far-side model: operator switches and weld current sensor
`timescale 1ns/100ps
module weld_cell_model
  import weld_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire weld_pkg::pins_out_t        pinsOut,
  input  wire weld_pkg::pins_in_t         switchCmd,
  input  wire logic [weld_pkg::CUR_W-1:0] currentLevel,
  output weld_pkg::pins_in_t              pinsIn,
  output logic      [weld_pkg::CUR_W-1:0] currentValue,
  output logic                            currentValid
);
  import weld_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // switch contacts follow the operator one clock late
  always_ff @(posedge clk) begin
    pinsIn <= switchCmd;
  end

  // current flows only with contactor and a closed valve; noise otherwise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      currentValid <= 1'h0;
      currentValue <= 12'h000;
    end else begin
      currentValid <= pinsOut.isolationContactorOutput
                      && (|pinsOut.headValves);
      currentValue <= pinsOut.isolationContactorOutput ? currentLevel
                                                       : ~currentValue;
    end
  end
endmodule // weld_cell_model

// ---- bench/testbench.sv ----
// self-checking bench of the part-hold weld sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
`define WAITFOR(c, n) begin int k; k = 0; while (!(c) && k < (n)) begin \
  @(posedge clk); #1; k++; end `CHK(c, 1'h1) end
module testbench;
  import weld_pkg::*;
  localparam int       LINE_P  = 4;
  localparam pins_in_t IDLE_SW = 5'h08;
  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata;
  logic              regWrite;
  logic              regRead;
  logic [DATA_W-1:0] regRdata;
  pins_in_t          switchCmd;
  pins_in_t          pinsIn;
  pins_out_t         pinsOut;
  logic [CUR_W-1:0]  currentLevel;
  logic [CUR_W-1:0]  currentValue;
  logic              currentValid;
  logic              irq;
  logic [2:0]        seenValves;
  logic [3:0]        seenAux;
  int                failures;
  int                checkCount;
  int                hiCycles;

  always #2.5 clk = ~clk;

  weld_sequencer #(.LINE_CLKS_P(LINE_P)) i_dut (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .pinsIn(pinsIn),
    .currentValue(currentValue), .currentValid(currentValid),
    .pinsOut(pinsOut), .irq(irq));
  weld_cell_model i_cell (.clk(clk), .rst_n(rst_n), .pinsOut(pinsOut),
    .switchCmd(switchCmd), .currentLevel(currentLevel), .pinsIn(pinsIn),
    .currentValue(currentValue), .currentValid(currentValid));

  //////////////////////////////////////////////////////////////////////////////
  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'h1;
    @(posedge clk);
    regWrite <= 1'h0;
  endtask

  task automatic regChk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge clk);
    regRead <= 1'h0;
    #1;
    `CHK(regRdata, e)
  endtask

  // initiate, then watch until the contactor drops
  task automatic runWeld(input logic [11:0] lvl, input bit keep = 1'b0);
    hiCycles = 0;
    seenValves = 3'h0;
    seenAux = 4'h0;
    @(posedge clk);
    currentLevel <= lvl;
    switchCmd.firstStageInitiate <= 1'h1;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      if (i == 2 && !keep) switchCmd.firstStageInitiate <= 1'h0;
      #1;
      if (pinsOut.isolationContactorOutput) begin
        hiCycles++;
        seenValves = seenValves | pinsOut.headValves;
        seenAux = seenAux | pinsOut.auxEventOutputs;
      end else if (hiCycles > 0) break;
    end
    `CHK(hiCycles > 0, 1'h1)
  endtask

  task automatic faultRun(input logic [31:0] ctrl, input logic [11:0] lvl);
    regWr(OFS_CTRL, ctrl);
    runWeld(lvl);
    `CHK(pinsOut.headValves, 3'h1)
    `CHK(pinsOut.isolationContactorOutput, 1'h0)
    `CHK(pinsOut.faultAlarmOutput, 1'h1)
    regChk(OFS_STATUS, 32'h0000_0304);
  endtask

  task automatic holdTry(input pins_in_t press, input logic rel);
    @(posedge clk);
    switchCmd <= IDLE_SW ^ press;
    repeat (5) @(posedge clk);
    #1;
    `CHK(pinsOut.headValves, rel ? 3'h0 : 3'h1)
    `CHK(pinsOut.faultAlarmOutput, ~rel)
    if (rel) `CHK(pinsOut.controlRelay, 1'h0)
    @(posedge clk);
    switchCmd <= IDLE_SW;
    if (rel) begin
      `WAITFOR(pinsOut.controlRelay, 2100)
      regChk(OFS_STATUS, 32'h0000_0000);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    complete_run();
  end

  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    regWrite = 1'h0;
    regRead = 1'h0;
    switchCmd = IDLE_SW;
    currentLevel = 12'h000;
    failures = 0;
    checkCount = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    regChk(OFS_CTRL, 32'h0000_0000);
    regChk(OFS_HI_LIM, 32'h0000_0FFF);
    regChk(OFS_LO_LIM, 32'h0000_0000);
    regWr(OFS_CTRL, 32'hFFFF_FFFF);
    regChk(OFS_CTRL, CTRL_MASK);
    regWr(8'h24, 32'hFFFF_FFFF);
    regChk(8'h24, 32'h0000_0000);
    regWr(OFS_STATUS, 32'h0000_0007);
    regChk(OFS_STATUS, 32'h0000_0000);
    $display("test registers done");
    regWr(OFS_HI_LIM, 32'h0000_0800);
    regWr(OFS_LO_LIM, 32'h0000_0100);
    regWr(OFS_IRQ_EN, 32'h0000_0001);
    regWr(OFS_SCH_SEL, 32'h0000_0000);
    regWr(OFS_SCH_DATA, 32'h0101_012A);
    regWr(OFS_CTRL, 32'h0000_0F03); // sequencer function off
    runWeld(12'h400);
    `CHK(hiCycles >= 3 * LINE_P && hiCycles <= 3 * LINE_P + 2, 1'h1)
    `CHK(seenValves, 3'h1)
    `CHK(seenAux, 4'h5)
    `CHK(pinsOut.headValves, 3'h0)
    `CHK(irq, 1'h1)
    regChk(OFS_IRQ_STAT, 32'h0000_0001);
    regWr(OFS_IRQ_CLR, 32'h0000_0007);
    regChk(OFS_IRQ_STAT, 32'h0000_0000);
    `CHK(irq, 1'h0)
    regWr(OFS_CTRL, 32'h0000_0F02);
    runWeld(12'hA00);
    `CHK(pinsOut.headValves, 3'h0)
    `CHK(pinsOut.faultAlarmOutput, 1'h0)
    regWr(OFS_IRQ_CLR, 32'h0000_0007);
    $display("test normal weld done");
    faultRun(32'h0000_0F03, 12'hA00);
    `CHK(irq, 1'h0)
    regChk(OFS_IRQ_STAT, 32'h0000_0002);
    holdTry(5'h02, 1'h0);
    holdTry(5'h04, 1'h1);
    regChk(OFS_IRQ_STAT, 32'h0000_0006);
    faultRun(32'h0000_0F0B, 12'h050);
    holdTry(5'h04, 1'h0);
    holdTry(5'h05, 1'h1);
    faultRun(32'h0000_0F05, 12'hA00);
    holdTry(5'h02, 1'h1);
    faultRun(32'h0000_0F01, 12'hA00);
    holdTry(5'h08, 1'h1);
    $display("test part hold done");
    regWr(OFS_SCH_DATA, 32'h0101_012B);
    regWr(OFS_SCH_SEL, 32'h0000_0001);
    regWr(OFS_SCH_DATA, 32'h0101_0154);
    regWr(OFS_CTRL, 32'h0000_0F03);
    runWeld(12'h400, 1'b1);
    `CHK(seenValves, 3'h3)
    `CHK(seenAux, 4'hF)
    repeat (20) @(posedge clk);
    #1;
    `CHK(pinsOut.isolationContactorOutput, 1'h0)
    `CHK(pinsOut.headValves, 3'h0)
    @(posedge clk);
    switchCmd.firstStageInitiate <= 1'h0;
    $display("test chained schedules done");
    regWr(OFS_SCH_DATA, 32'h0201_0354);
    regWr(OFS_CTRL, 32'h0001_0313);
    runWeld(12'h400);
    `CHK(hiCycles >= 6 * LINE_P && hiCycles <= 6 * LINE_P + 2, 1'h1)
    `CHK(seenValves, 3'h2)
    `CHK(seenAux, 4'h0)
    regChk(OFS_STATUS, 32'h0000_0010);
    regWr(OFS_CTRL, 32'h0001_0303);
    runWeld(12'h400);
    `CHK(seenAux, 4'h2)
    $display("test options done");
    complete_run();
  end
endmodule // testbench
